// ### common/cpsl_pkg.sv
// Shared constants and carrier types of the page-selecting configuration loader.
`default_nettype none
package cpsl_pkg;
	localparam int          PAGE_BITS     = 3;
	localparam int          PAGES         = 8;
	localparam int          ADDR_W        = 24;
	localparam int          FDATA_W       = 16;
	localparam int          CDATA_W       = 8;
	localparam logic [2:0]  DEFAULT_PAGE  = 3'h0;
	localparam logic [ADDR_W-1:0] OPT_BASE = 24'h000000;
	localparam logic [ADDR_W-1:0] OPT_STEP = 24'h000004;
	localparam logic [1:0]  OPT_WORDS     = 2'h3;
	localparam int          CLK_MHZ       = 40;
	localparam int          FLASH_ACC_NS  = 90;
	localparam int          FLASH_CYC     = (FLASH_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  FLASH_WAIT    = 4'(FLASH_CYC);
	localparam logic [1:0]  MODE_PS1      = 2'h0;
	localparam logic [1:0]  MODE_PS2      = 2'h1;
	localparam logic [1:0]  MODE_PS4      = 2'h2;
	localparam logic [1:0]  MODE_PS8      = 2'h3;

	typedef struct packed {
		logic [ADDR_W-1:0] start;
		logic [ADDR_W-1:0] length;
	} cpsl_page_s;

	typedef struct packed {
		logic               valid;
		logic [CDATA_W-1:0] data;
	} cpsl_byte_s;
endpackage
`default_nettype wire

// ### hw/cpsl_expander.sv
// Streaming expander: run-length decompression of flash words, or plain bypass.
`timescale 1ns/10ps
`default_nettype none
module cpsl_expander
(
	input  wire logic                         clk,      // System clock.
	input  wire logic                         rst_n,    // Asynchronous reset, active low.
	input  wire logic                         clear,    // Restart at a page boundary.
	input  wire logic                         compress, // Compression mode on.
	input  wire logic                         in_valid, // Flash word offered.
	input  wire logic [cpsl_pkg::FDATA_W-1:0] in_data,  // Flash word.
	output logic                              in_ready, // Word can be taken.
	output cpsl_pkg::cpsl_byte_s              out_byte, // Expanded byte.
	input  wire logic                         out_ready // Consumer takes the byte.
);
	// A word holds two bytes; in compressed form the high byte is a repeat count and the
	// low byte the value, so one 16-bit read can yield up to 256 output bytes.
	logic [cpsl_pkg::FDATA_W-1:0] word;
	logic [8:0]                   left;
	logic                         busy;
	logic                         emit;

	assign in_ready = !busy;
	assign emit     = busy && (!out_byte.valid || out_ready);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			word <= 16'h0000;
			left <= 9'h000;
			busy <= 1'b0;
		end
		else if (clear)
		begin
			busy <= 1'b0;
			left <= 9'h000;
		end
		else if (!busy && in_valid)
		begin
			word <= in_data;
			busy <= 1'b1;
			if (compress)
				left <= {1'b0, in_data[15:8]} + 9'h001;
			else
				left <= 9'h002;
		end
		else if (emit)
		begin
			if (left == 9'h001)
				busy <= 1'b0;
			left <= left - 9'h001;
			if (!compress)
				word <= {8'h00, word[15:8]};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			out_byte <= '0;
		else if (clear)
			out_byte <= '0;
		else if (emit)
		begin
			out_byte.valid <= 1'b1;
			out_byte.data  <= word[7:0];
		end
		else if (out_ready)
			out_byte.valid <= 1'b0;
	end
endmodule
`default_nettype wire

// ### hw/cpsl_loader.sv
// Top of the page-selecting configuration loader: option bits, flash reads, FPGA output.
`timescale 1ns/10ps
`default_nettype none
module cpsl_loader
(
	input  wire logic                         CLK_SYS,       // 40 MHz clock.
	input  wire logic                         RST_N,         // Power-on reset, active low.
	input  wire logic                         RUN_GATE,      // Status/output-enable pin.
	input  wire logic [2:0]                   PAGE_SELECT,   // Page number pins.
	input  wire logic                         COMPRESS,      // Compression mode strap.
	input  wire logic                         PARALLEL,      // Byte-wide mode strap.
	input  wire logic [1:0]                   SERIAL_WIDTH,  // Concurrent serial lanes.
	output logic [cpsl_pkg::ADDR_W-1:0]       FLASH_ADDR,    // Flash address.
	output logic                              FLASH_CE_N,    // Flash chip enable, low.
	output logic                              FLASH_OE_N,    // Flash read enable, low.
	output logic                              FLASH_BUS_OE,  // Controller drives flash bus.
	input  wire logic [cpsl_pkg::FDATA_W-1:0] FLASH_DATA,    // Flash read data.
	output logic                              DCLK,          // Configuration clock out.
	output logic [cpsl_pkg::CDATA_W-1:0]      DATA,          // Configuration data out.
	output logic                              DONE_LOAD,     // Page fully delivered.
	output logic [2:0]                        ACTIVE_PAGE    // Page in use.
);
	typedef enum {ST_POR, ST_OPT, ST_IDLE, ST_READ, ST_WAIT, ST_DRAIN, ST_DONE} cpsl_state_e;

	cpsl_state_e          state;
	cpsl_pkg::cpsl_page_s table_q [cpsl_pkg::PAGES];
	logic [2:0]           opt_page;
	logic [1:0]           opt_word;
	logic [3:0]           wait_cnt;
	logic [2:0]           gate_sync;
	logic [8:0]           sel_sync;
	logic                 gate;
	logic                 gate_q;
	logic [2:0]           page_live;
	logic                 options_ok;
	logic [cpsl_pkg::ADDR_W-1:0] addr;
	logic [cpsl_pkg::ADDR_W-1:0] remain;
	logic                 word_valid;
	logic [15:0]          word_data;
	logic                 word_ready;
	cpsl_pkg::cpsl_byte_s exp_byte;
	logic                 byte_take;
	logic [7:0]           shreg;
	logic [3:0]           bits_left;
	logic                 phase;

	function automatic logic [3:0] lanes(input logic [1:0] w);
		case (w)
			cpsl_pkg::MODE_PS1: lanes = 4'h1;
			cpsl_pkg::MODE_PS2: lanes = 4'h2;
			cpsl_pkg::MODE_PS4: lanes = 4'h4;
			default:            lanes = 4'h8;
		endcase
	endfunction

	// Pins from the board pass three flops; a level counts once the last two agree.
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			gate_sync <= 3'h0;
			sel_sync  <= 9'h000;
			gate      <= 1'b0;
			page_live <= cpsl_pkg::DEFAULT_PAGE;
		end
		else
		begin
			gate_sync <= {gate_sync[1:0], RUN_GATE};
			sel_sync  <= {sel_sync[5:0], PAGE_SELECT};
			if (gate_sync[2] == gate_sync[1])
				gate <= gate_sync[2];
			if (sel_sync[8:6] == sel_sync[5:3])
				page_live <= sel_sync[8:6];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			gate_q <= 1'b0;
		else
			gate_q <= gate;
	end

	// Flash fetch and page sequencing.
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state      <= ST_POR;
			opt_page   <= 3'h0;
			opt_word   <= 2'h0;
			wait_cnt   <= 4'h0;
			options_ok <= 1'b0;
			addr       <= '0;
			remain     <= '0;
			word_valid <= 1'b0;
			word_data  <= 16'h0000;
			FLASH_ADDR <= '0;
			FLASH_CE_N <= 1'b1;
			FLASH_OE_N <= 1'b1;
			FLASH_BUS_OE <= 1'b0;
			DONE_LOAD  <= 1'b0;
			ACTIVE_PAGE <= cpsl_pkg::DEFAULT_PAGE;
		end
		else if (!gate && options_ok)
		begin
			state        <= ST_IDLE;
			FLASH_CE_N   <= 1'b1;
			FLASH_OE_N   <= 1'b1;
			FLASH_BUS_OE <= 1'b0;
			word_valid   <= 1'b0;
			DONE_LOAD    <= 1'b0;
		end
		else
		begin
			if (word_valid && word_ready)
				word_valid <= 1'b0;
			case (state)
				ST_POR:
				begin
					FLASH_ADDR   <= cpsl_pkg::OPT_BASE;
					FLASH_CE_N   <= 1'b0;
					FLASH_OE_N   <= 1'b0;
					FLASH_BUS_OE <= 1'b1;
					wait_cnt     <= cpsl_pkg::FLASH_WAIT;
					state        <= ST_OPT;
				end
				ST_OPT:
				begin
					if (wait_cnt != 4'h0)
						wait_cnt <= wait_cnt - 4'h1;
					else
					begin
						case (opt_word)
							2'h0: table_q[opt_page].start[23:16]  <= FLASH_DATA[7:0];
							2'h1: table_q[opt_page].start[15:0]   <= FLASH_DATA;
							2'h2: table_q[opt_page].length[23:16] <= FLASH_DATA[7:0];
							default: table_q[opt_page].length[15:0] <= FLASH_DATA;
						endcase
						FLASH_ADDR <= FLASH_ADDR + 24'h000001;
						wait_cnt   <= cpsl_pkg::FLASH_WAIT;
						opt_word   <= opt_word + 2'h1;
						if (opt_word == cpsl_pkg::OPT_WORDS)
						begin
							opt_page <= opt_page + 3'h1;
							if (opt_page == 3'(cpsl_pkg::PAGES - 1))
							begin
								options_ok   <= 1'b1;
								FLASH_CE_N   <= 1'b1;
								FLASH_OE_N   <= 1'b1;
								FLASH_BUS_OE <= 1'b0;
								state        <= ST_IDLE;
							end
						end
					end
				end
				ST_IDLE:
				begin
					if (gate && !gate_q)
					begin
						ACTIVE_PAGE <= page_live;
						addr        <= table_q[page_live].start;
						remain      <= table_q[page_live].length;
						state       <= ST_READ;
					end
				end
				ST_READ:
				begin
					if (remain == '0)
						state <= ST_DRAIN;
					else if (!word_valid)
					begin
						FLASH_ADDR   <= addr;
						FLASH_CE_N   <= 1'b0;
						FLASH_OE_N   <= 1'b0;
						FLASH_BUS_OE <= 1'b1;
						wait_cnt     <= cpsl_pkg::FLASH_WAIT;
						state        <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (wait_cnt != 4'h0)
						wait_cnt <= wait_cnt - 4'h1;
					else
					begin
						word_data  <= FLASH_DATA;
						word_valid <= 1'b1;
						addr       <= addr + 24'h000001;
						remain     <= remain - 24'h000001;
						state      <= ST_READ;
					end
				end
				ST_DRAIN:
				begin
					FLASH_CE_N   <= 1'b1;
					FLASH_OE_N   <= 1'b1;
					FLASH_BUS_OE <= 1'b0;
					if (!word_valid && word_ready && !exp_byte.valid && bits_left == 4'h0)
						state <= ST_DONE;
				end
				default:
					DONE_LOAD <= 1'b1;
			endcase
		end
	end

	cpsl_expander u_expander
	(
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.clear     (state == ST_IDLE),
		.compress  (COMPRESS),
		.in_valid  (word_valid),
		.in_data   (word_data),
		.in_ready  (word_ready),
		.out_byte  (exp_byte),
		.out_ready (byte_take)
	);

	// Output serialiser: DCLK runs at half the system rate within a byte, plus one low cycle to load each byte; data changes only while it is low.
	assign byte_take = (bits_left == 4'h0) && !phase;

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			phase     <= 1'b0;
			shreg     <= 8'h00;
			bits_left <= 4'h0;
			DCLK      <= 1'b0;
			DATA      <= 8'h00;
		end
		else if (!gate)
		begin
			phase     <= 1'b0;
			bits_left <= 4'h0;
			DCLK      <= 1'b0;
			DATA      <= 8'h00;
		end
		else if (!phase)
		begin
			if (bits_left != 4'h0)
			begin
				phase <= 1'b1;
				DCLK  <= 1'b1;
			end
			else if (exp_byte.valid)
			begin
				if (PARALLEL)
				begin
					DATA      <= exp_byte.data;
					bits_left <= 4'h1;
				end
				else
				begin
					DATA      <= exp_byte.data & ~(8'hff << lanes(SERIAL_WIDTH));
					shreg     <= exp_byte.data;
					bits_left <= 4'h8;
				end
			end
		end
		else
		begin
			phase     <= 1'b0;
			DCLK      <= 1'b0;
			bits_left <= bits_left - (PARALLEL ? 4'h1 : lanes(SERIAL_WIDTH));
			if (!PARALLEL && bits_left > lanes(SERIAL_WIDTH))
			begin
				// Concurrent serial lanes each carry one bit; unused lanes drive low.
				shreg <= shreg >> lanes(SERIAL_WIDTH);
				DATA  <= (shreg >> lanes(SERIAL_WIDTH)) & ~(8'hff << lanes(SERIAL_WIDTH));
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/cpsl_loader_checker.sv
// Port assertions for the page-selecting configuration loader.
`timescale 1ns/10ps
`default_nettype none
module cpsl_loader_checker
(
	input wire logic        CLK_SYS,      // Clock.
	input wire logic        RST_N,        // Reset.
	input wire logic        RUN_GATE,     // Run gate.
	input wire logic [2:0]  PAGE_SELECT,  // Page pins.
	input wire logic        COMPRESS,     // Compression.
	input wire logic        PARALLEL,     // Byte mode.
	input wire logic [1:0]  SERIAL_WIDTH, // Lanes.
	input wire logic [23:0] FLASH_ADDR,   // Address.
	input wire logic        FLASH_CE_N,   // Enable.
	input wire logic        FLASH_OE_N,   // Read.
	input wire logic        FLASH_BUS_OE, // Drive.
	input wire logic [15:0] FLASH_DATA,   // Data in.
	input wire logic        DCLK,         // Data clock.
	input wire logic [7:0]  DATA,         // Data out.
	input wire logic        DONE_LOAD,    // Done.
	input wire logic [2:0]  ACTIVE_PAGE   // Page.
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Power-on option reads happen with the gate low, so idle is only judged after a gate.
	logic seen_gate;
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			seen_gate <= 1'b0;
		else if (RUN_GATE)
			seen_gate <= 1'b1;
	end
	page_pins_a: assert property (!$stable(ACTIVE_PAGE) |->
		ACTIVE_PAGE == $past(PAGE_SELECT, 3) || ACTIVE_PAGE == $past(PAGE_SELECT, 4))
		else $error("Latched page differs from pins.");
	page_gate_a: assert property (!$stable(ACTIVE_PAGE) |-> $past(RUN_GATE, 2))
		else $error("Page latched without gate.");
	page_hold_a: assert property (RUN_GATE [*8] |-> $stable(ACTIVE_PAGE))
		else $error("Page changed inside a cycle.");
	done_hold_a: assert property (DONE_LOAD && RUN_GATE |=> DONE_LOAD)
		else $error("Done dropped with gate high.");
	done_clear_a: assert property ($fell(RUN_GATE) |-> ##[1:6] !DONE_LOAD)
		else $error("Done kept after gate low.");
	gate_idle_a: assert property ((seen_gate && !RUN_GATE) [*8] |->
		FLASH_CE_N && !FLASH_BUS_OE && $stable(DCLK))
		else $error("Activity with gate low.");
	addr_hold_a: assert property (!FLASH_CE_N && !$stable(FLASH_ADDR) |=>
		$stable(FLASH_ADDR) [*3])
		else $error("Flash address not held.");
	read_pair_a: assert property (!FLASH_OE_N |-> !FLASH_CE_N && FLASH_BUS_OE)
		else $error("Read without enable.");
	data_rise_a: assert property (DCLK |-> $stable(DATA))
		else $error("Data moved with clock high.");
	lane_zero_a: assert property (DCLK && !PARALLEL && SERIAL_WIDTH == 2'h0 |->
		DATA[7:1] == 7'h00)
		else $error("Unused lane driven.");
	cover property (DONE_LOAD && ACTIVE_PAGE == 3'h7);
	cover property (DONE_LOAD && COMPRESS);
	cover property (DONE_LOAD && !PARALLEL);
endmodule
bind cpsl_loader cpsl_loader_checker chk (.CLK_SYS, .RST_N, .RUN_GATE, .PAGE_SELECT,
	.COMPRESS, .PARALLEL, .SERIAL_WIDTH, .FLASH_ADDR, .FLASH_CE_N, .FLASH_OE_N,
	.FLASH_BUS_OE, .FLASH_DATA, .DCLK, .DATA, .DONE_LOAD, .ACTIVE_PAGE);
`default_nettype wire

// ### tb/cpsl_fpga_model.sv
// Receiver model: rebuilds bytes from the data lanes, lowest bits first.
`timescale 1ns/10ps
`default_nettype none
module cpsl_fpga_model
(
	input wire logic       dclk,     // Data clock.
	input wire logic [7:0] data,     // Lanes.
	input wire logic       parallel, // Byte mode.
	input wire logic [1:0] width     // Lane code.
);
	logic [7:0] rx_q[$];
	logic [7:0] shift;
	int         fill = 0;
	int         lanes;
	// Data is taken on the rising clock, where the sender keeps it steady.
	always @(posedge dclk)
	begin
		lanes = parallel ? 8 : (1 << width);
		shift = 8'((shift >> lanes) | ((data & 8'((1 << lanes) - 1)) << (8 - lanes)));
		fill = fill + lanes;
		if (fill == 8)
		begin
			rx_q.push_back(shift);
			fill = 0;
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_config_page_select_loader.sv
// Self-checking bench for the page-selecting configuration loader.
`timescale 1ns/10ps
`default_nettype none
module tb_config_page_select_loader;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        run_gate = 1'b0;
	logic [2:0]  page_select = 3'h0;
	logic        compress = 1'b0;
	logic        parallel = 1'b1;
	logic [1:0]  serial_width = 2'h0;
	logic [23:0] flash_addr;
	logic [23:0] last_addr;
	logic        flash_ce_n;
	logic        flash_oe_n;
	logic [15:0] flash_data;
	logic [15:0] stored;
	logic [3:0]  hold = 4'h0;
	logic        dclk;
	logic [7:0]  data;
	logic        done_load;
	logic [2:0]  active_page;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cycles = 0;
	always #12.5 clk_sys = ~clk_sys;
	// Option rows: page p starts at word 0x100 + 16p and is two words long.
	function automatic logic [15:0] word_at(input logic [23:0] a);
		if (a < 24'h000020)
			return (a[1:0] == 2'h1) ? 16'h0100 | {9'h0, a[4:2], 4'h0}
				: {14'h0, a[1:0] == 2'h3, 1'b0};
		return {6'h0, a[1:0], a[7:0]};
	endfunction
	// Until the access time has run, the flash shows the inverse word, not a stale one.
	always @(posedge clk_sys)
	begin
		hold <= (flash_addr == last_addr && hold != 4'hf) ? hold + 4'h1 : 4'h0;
		last_addr <= flash_addr;
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			finish_test();
		end
	end
	assign stored = word_at(flash_addr);
	// Three steady cycles cover the access time, so a read taken one cycle early sees junk.
	assign flash_data = (!flash_ce_n && !flash_oe_n && hold >= 4'h3) ? stored : ~stored;
	cpsl_loader uut
	(
		.CLK_SYS      (clk_sys),
		.RST_N        (rst_n),
		.RUN_GATE     (run_gate),
		.PAGE_SELECT  (page_select),
		.COMPRESS     (compress),
		.PARALLEL     (parallel),
		.SERIAL_WIDTH (serial_width),
		.FLASH_ADDR   (flash_addr),
		.FLASH_CE_N   (flash_ce_n),
		.FLASH_OE_N   (flash_oe_n),
		.FLASH_BUS_OE (),
		.FLASH_DATA   (flash_data),
		.DCLK         (dclk),
		.DATA         (data),
		.DONE_LOAD    (done_load),
		.ACTIVE_PAGE  (active_page)
	);
	cpsl_fpga_model fpga
	(
		.dclk     (dclk),
		.data     (data),
		.parallel (parallel),
		.width    (serial_width)
	);
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic run_page(input logic [2:0] p, input logic comp, input logic par,
		input logic [1:0] sw);
		logic [7:0]  exp_q[$];
		logic [23:0] a;
		int          n;
		n = 0;
		run_gate <= 1'b0;
		page_select <= p;
		compress <= comp;
		parallel <= par;
		serial_width <= sw;
		repeat (8) @(posedge clk_sys);
		fpga.rx_q.delete();
		fpga.fill = 0;
		run_gate <= 1'b1;
		repeat (12) @(posedge clk_sys);
		page_select <= ~p;
		while (done_load !== 1'b1 && n < 3000)
		begin
			@(posedge clk_sys);
			n++;
		end
		for (a = 24'h100 + {p, 4'h0}; a < 24'h102 + {p, 4'h0}; a++)
		begin
			if (comp)
				repeat (a[1:0] + 1) exp_q.push_back(a[7:0]);
			else
			begin
				exp_q.push_back(a[7:0]);
				exp_q.push_back({6'h0, a[1:0]});
			end
		end
		check("done", 1'b1, done_load);
		check("page", p, active_page);
		check("count", 24'(exp_q.size()), 24'(fpga.rx_q.size()));
		foreach (exp_q[i])
			check("byte", exp_q[i], fpga.rx_q[i]);
	endtask
	task automatic t_reset;
		int n;
		n = 0;
		run_gate <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		while (flash_ce_n !== 1'b0 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		check("read start", 1'b0, flash_ce_n);
		check("first read", cpsl_pkg::OPT_BASE, flash_addr);
		repeat (300) @(posedge clk_sys);
		$display("test reset done");
	endtask
	task automatic t_pages;
		for (int p = 0; p < 8; p++)
			run_page(3'(p), 1'b0, 1'b1, 2'h0);
		$display("test pages done");
	endtask
	task automatic t_serial;
		for (int w = 0; w < 4; w++)
			run_page(3'h5, 1'b0, 1'b0, 2'(w));
		$display("test serial done");
	endtask
	task automatic t_compress;
		run_page(3'h6, 1'b1, 1'b1, 2'h0);
		run_page(3'h2, 1'b1, 1'b0, 2'h2);
		$display("test compress done");
	endtask
	task automatic t_default;
		t_reset();
		run_page(3'h0, 1'b0, 1'b1, 2'h0);
		$display("test default done");
	endtask
	initial
	begin
		t_reset();
		t_pages();
		t_serial();
		t_compress();
		t_default();
		finish_test();
	end
endmodule
`default_nettype wire
